//--- burst_corrector_defs.svh
`ifndef BURST_CORRECTOR_DEFS_SVH
`define BURST_CORRECTOR_DEFS_SVH

// Register byte offsets on the bus.
`define OFS_CONTROL      8'h00
`define OFS_ERROR1       8'h04
`define OFS_STATUS       8'h08
`define OFS_POSITION     8'h0C
`define OFS_PATTERN      8'h10
`define OFS_CHECK        8'h14
`define OFS_SHIFTS       8'h18

// Field positions.
`define BIT_INHIBIT      0
`define BIT_FORMAT18     1
`define BIT_DATA_CHECK   15
`define BIT_UNCORRECT    14
`define BIT_ST_CORR_EN   0
`define BIT_ST_ENTERED   1
`define BIT_ST_READY     2
`define BIT_ST_ZERO      3
`define BIT_ST_ATTN      4

// Check register geometry.
`define CHECK_WIDTH      32
`define ZERO_BITS        21
`define PATTERN_LSB      21
`define PATTERN_BITS     11

// Arbitrary default generator polynomial and leading-zero counts.
`define CHECK_POLY       32'h0000_0001
`define LEAD_ZEROS_16    16'h0040
`define LEAD_ZEROS_18    16'h0040

// Shifts after data-field entry before a hard error is declared.
`define HARD_LIMIT_16    16'h1020
`define HARD_LIMIT_18    16'h1220

`endif

//--- burst_corrector_pkg.sv
package burst_corrector_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CHECK,
		ST_CORRECT,
		ST_DONE
	} state_e;

	typedef struct packed {
		state_e      state;
		logic [31:0] check;
		logic [15:0] shift_cnt;
		logic [15:0] pos_cnt;
		logic        entered;
		logic        corr_en;
		logic        ready;
		logic        data_check_error;
		logic        uncorrectable_error;
		logic        attn;
		logic        inhibit;
		logic        fmt18;
		logic        env_d;
		logic        end_pulse;
		logic        ack;
		logic [31:0] dat;
	} core_s;

endpackage

//--- burst_corrector.sv
`timescale 1ns/100ps
`include "burst_corrector_defs.svh"

module burst_corrector #(
	parameter logic [15:0] LEAD_ZEROS_16 = `LEAD_ZEROS_16, // Leading zeros.
	parameter logic [15:0] LEAD_ZEROS_18 = `LEAD_ZEROS_18, // Leading zeros.
	parameter logic [15:0] HARD_LIMIT_16 = `HARD_LIMIT_16, // Hard limit.
	parameter logic [15:0] HARD_LIMIT_18 = `HARD_LIMIT_18, // Hard limit.
	parameter logic [31:0] CHECK_POLY    = `CHECK_POLY     // Generator.
) (
	input  wire logic        clk,               // 200 MHz clock.
	input  wire logic        rst_n,             // Synchronous reset.
	input  wire logic        wb_cyc_i,          // Bus cycle.
	input  wire logic        wb_stb_i,          // Bus strobe.
	input  wire logic        wb_we_i,           // Bus write.
	input  wire logic [7:0]  wb_adr_i,          // Byte address.
	input  wire logic [3:0]  wb_sel_i,          // Byte enables.
	input  wire logic [31:0] wb_dat_i,          // Write data.
	output logic      [31:0] wb_dat_o,          // Read data.
	output logic             wb_ack_o,          // Bus acknowledge.
	input  wire logic        read_active,       // Read command running.
	input  wire logic        data_envelope,     // Data field window.
	input  wire logic        check_envelope,    // Check field window.
	input  wire logic        serial_bit,        // Bit read from disk.
	output logic             sector_end_signal, // End-of-block pulse.
	output logic             attention,         // Composite error level.
	output logic             correction_ready   // Burst trapped level.
);

	////////////////////////////////////////////////////////////////////////
	// State and combinational helpers.

	burst_corrector_pkg::core_s r;
	burst_corrector_pkg::core_s n;

	logic        syndrome_all_zero;
	logic        feedback_gate_enable;
	logic        check_end;
	logic        set_data_check;
	logic        data_check_active;
	logic        hard_error_detected;
	logic        bus_req;
	logic [15:0] lead_count;
	logic [15:0] hard_limit;
	logic [31:0] read_mux;

	// One serial step of the check register with polynomial feedback.
	function automatic logic [31:0] check_step(input logic [31:0] c,
		input logic b);
		logic fb;
		fb = c[`CHECK_WIDTH-1] ^ b;
		return {c[30:0], 1'b0} ^ ({32{fb}} & CHECK_POLY);
	endfunction

	assign syndrome_all_zero = ~|r.check[`ZERO_BITS-1:0];
	assign check_end = r.env_d && !check_envelope
		&& r.state == burst_corrector_pkg::ST_CHECK;
	assign set_data_check = check_end && !syndrome_all_zero;
	assign data_check_active = set_data_check;
	assign feedback_gate_enable = (read_active
		&& (data_envelope || check_envelope))
		|| r.corr_en;
	assign lead_count = r.fmt18 ? LEAD_ZEROS_18 : LEAD_ZEROS_16;
	assign hard_limit = r.fmt18 ? HARD_LIMIT_18 : HARD_LIMIT_16;
	assign hard_error_detected = r.corr_en && r.entered && !syndrome_all_zero
		&& r.pos_cnt == hard_limit;
	assign bus_req = wb_cyc_i && wb_stb_i;

	always_comb begin
		read_mux = 32'h0000_0000;
		case (wb_adr_i)
			`OFS_CONTROL: begin
				read_mux[`BIT_INHIBIT] = r.inhibit;
				read_mux[`BIT_FORMAT18] = r.fmt18;
			end
			`OFS_ERROR1: begin
				read_mux[`BIT_DATA_CHECK] = r.data_check_error;
				read_mux[`BIT_UNCORRECT] = r.uncorrectable_error;
			end
			`OFS_STATUS: begin
				read_mux[`BIT_ST_CORR_EN] = r.corr_en;
				read_mux[`BIT_ST_ENTERED] = r.entered;
				read_mux[`BIT_ST_READY] = r.ready;
				read_mux[`BIT_ST_ZERO] = syndrome_all_zero;
				read_mux[`BIT_ST_ATTN] = r.attn;
			end
			`OFS_POSITION: read_mux[15:0] = r.pos_cnt;
			`OFS_PATTERN: begin
				read_mux[`PATTERN_BITS-1:0] =
					r.check[`CHECK_WIDTH-1:`PATTERN_LSB];
			end
			`OFS_CHECK: read_mux = r.check;
			`OFS_SHIFTS: read_mux[15:0] = r.shift_cnt;
			default: read_mux = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic. Bus clears come first so that hardware sets win.

	always_comb begin
		n = r;
		n.end_pulse = 1'b0;
		n.ack = 1'b0;
		n.env_d = check_envelope;

		if (bus_req && !r.ack) begin
			n.ack = 1'b1;
			n.dat = read_mux;
		end
		if (bus_req && r.ack && wb_we_i) begin
			if (wb_adr_i == `OFS_CONTROL && wb_sel_i[0]) begin
				n.inhibit = wb_dat_i[`BIT_INHIBIT];
				n.fmt18 = wb_dat_i[`BIT_FORMAT18];
			end
			if (wb_adr_i == `OFS_ERROR1 && wb_sel_i[1]) begin
				if (wb_dat_i[`BIT_DATA_CHECK]) begin
					n.data_check_error = 1'b0;
				end
				if (wb_dat_i[`BIT_UNCORRECT]) begin
					n.uncorrectable_error = 1'b0;
				end
			end
		end

		case (r.state)
			burst_corrector_pkg::ST_IDLE,
			burst_corrector_pkg::ST_DONE: begin
				if (read_active && data_envelope) begin
					// A new sector discards the previous result.
					n.state = burst_corrector_pkg::ST_CHECK;
					n.check = check_step(32'h0000_0000, serial_bit);
					n.ready = 1'b0;
					n.entered = 1'b0;
					n.shift_cnt = 16'h0000;
					n.pos_cnt = 16'h0000;
				end
			end
			burst_corrector_pkg::ST_CHECK: begin
				if (feedback_gate_enable) begin
					n.check = check_step(r.check, serial_bit);
				end
				if (check_end) begin
					if (!data_check_active) begin
						n.end_pulse = 1'b1;
						n.state = burst_corrector_pkg::ST_IDLE;
					end else begin
						n.data_check_error = 1'b1;
						if (r.inhibit) begin
							n.end_pulse = 1'b1;
							n.state = burst_corrector_pkg::ST_IDLE;
						end else begin
							n.corr_en = 1'b1;
							n.state = burst_corrector_pkg::ST_CORRECT;
						end
					end
				end else if (!read_active) begin
					n.state = burst_corrector_pkg::ST_IDLE;
				end
			end
			burst_corrector_pkg::ST_CORRECT: begin
				if (r.entered && syndrome_all_zero) begin
					// Trapped: freeze everything and release the sector.
					n.corr_en = 1'b0;
					n.ready = 1'b1;
					n.end_pulse = 1'b1;
					n.state = burst_corrector_pkg::ST_DONE;
				end else if (hard_error_detected) begin
					n.corr_en = 1'b0;
					n.uncorrectable_error = 1'b1;
					n.end_pulse = 1'b1;
					n.state = burst_corrector_pkg::ST_DONE;
				end else begin
					// Leading zeros and later shifts feed a zero input bit.
					n.check = check_step(r.check, 1'b0);
					n.shift_cnt = r.shift_cnt + 16'h0001;
					if (r.entered) begin
						n.pos_cnt = r.pos_cnt + 16'h0001;
					end else if (r.shift_cnt + 16'h0001 == lead_count) begin
						n.entered = 1'b1;
					end
				end
			end
			default: begin
				n.state = burst_corrector_pkg::ST_IDLE;
			end
		endcase

		n.attn = n.data_check_error || n.uncorrectable_error;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
	assign sector_end_signal = r.end_pulse;
	assign attention = r.attn;
	assign correction_ready = r.ready;

	////////////////////////////////////////////////////////////////////////
	// Checks on the correction sequence.

	default clocking cb_check @(posedge clk);
	endclocking

	default disable iff (!rst_n);

	sequence s_bad_end;
		set_data_check;
	endsequence

	sequence s_trap;
		r.state == burst_corrector_pkg::ST_CORRECT && r.entered
			&& syndrome_all_zero;
	endsequence

	a_check_flag_set: assert property (
		s_bad_end |=> r.data_check_error && attention)
		else $error("Data check flag not set after bad remainder.");

	a_end_withheld: assert property (@(posedge clk) disable iff (!rst_n)
		r.corr_en |-> !sector_end_signal)
		else $error("Sector end issued during correction.");

	a_inhibit_end: assert property (@(posedge clk) disable iff (!rst_n)
		s_bad_end ##0 r.inhibit |=> sector_end_signal && !r.corr_en)
		else $error("Inhibited data check did not end the sector.");

	a_corr_start: assert property (@(posedge clk) disable iff (!rst_n)
		s_bad_end ##0 !r.inhibit |=> r.corr_en && !sector_end_signal)
		else $error("Correction did not start after data check.");

	a_shift_count: assert property (@(posedge clk) disable iff (!rst_n)
		r.corr_en ##1 r.corr_en |-> r.shift_cnt == $past(r.shift_cnt) + 16'h0001)
		else $error("Shift counter did not advance while correcting.");

	a_field_entry: assert property (@(posedge clk) disable iff (!rst_n)
		r.corr_en && !r.entered && !hard_error_detected
		&& r.shift_cnt + 16'h0001 == lead_count |=> r.entered)
		else $error("Data field entry missed at leading-zero count.");

	a_trap_ready: assert property (@(posedge clk) disable iff (!rst_n)
		s_trap |=> correction_ready && !r.corr_en && sector_end_signal
		&& $stable(r.pos_cnt) && $stable(r.shift_cnt))
		else $error("Trapped burst did not freeze and signal ready.");

	a_ready_hold: assert property (@(posedge clk) disable iff (!rst_n)
		correction_ready && !(read_active && data_envelope)
		|=> $stable(r.check))
		else $error("Check register shifted while ready.");

	a_hard_error: assert property (@(posedge clk) disable iff (!rst_n)
		hard_error_detected |=> r.uncorrectable_error && sector_end_signal
		&& !r.corr_en)
		else $error("Hard error not flagged at limit.");

	a_zero_detect: assert property (@(posedge clk) disable iff (!rst_n)
		r.state == burst_corrector_pkg::ST_CHECK && check_end
		&& r.check[20:0] != 21'h000000 |=> !sector_end_signal || r.inhibit)
		else $error("Nonzero remainder ended the sector normally.");

	a_clean_end: assert property (
		check_end && syndrome_all_zero |=> sector_end_signal && !r.corr_en)
		else $error("Clean remainder did not end the sector.");

	a_feedback_on: assert property (
		r.corr_en && !(r.entered && syndrome_all_zero) && !hard_error_detected
		|-> feedback_gate_enable
		##1 r.check == check_step($past(r.check), 1'b0))
		else $error("Check register did not shift with feedback.");

	a_lead_count: assert property (
		$rose(r.entered) |-> r.shift_cnt == lead_count)
		else $error("Data field entered at the wrong shift count.");

	a_lead_hold: assert property (
		r.corr_en && !r.entered |=> $stable(r.pos_cnt))
		else $error("Position counted during leading zeros.");

	a_pos_advance: assert property (
		r.corr_en && r.entered && !syndrome_all_zero && !hard_error_detected
		|=> r.pos_cnt == $past(r.pos_cnt) + 16'h0001)
		else $error("Position counter did not advance after entry.");

	a_trap_window: assert property (
		r.state == burst_corrector_pkg::ST_CORRECT && !r.entered
		&& syndrome_all_zero |=> r.corr_en)
		else $error("Burst trapped before data field entry.");

	a_ready_end: assert property (
		$rose(correction_ready) |-> sector_end_signal)
		else $error("Correction ready without a sector end.");

	a_shift_frozen: assert property (
		r.state == burst_corrector_pkg::ST_DONE
		&& !(read_active && data_envelope) |=> $stable(r.shift_cnt))
		else $error("Shift counter moved after correction ended.");

	a_hard_bound: assert property (
		r.corr_en && r.entered |-> r.pos_cnt <= hard_limit)
		else $error("Position passed the hard-error threshold.");

	a_attn_level: assert property (
		r.data_check_error || r.uncorrectable_error |-> attention)
		else $error("Error flag set without attention.");

	a_read_feedback: assert property (
		r.state == burst_corrector_pkg::ST_CHECK && read_active
		&& (data_envelope || check_envelope)
		|=> r.check == check_step($past(r.check), $past(serial_bit)))
		else $error("Read bit did not enter the check register.");

	a_first_bit: assert property (
		r.state != burst_corrector_pkg::ST_CHECK
		&& r.state != burst_corrector_pkg::ST_CORRECT
		&& read_active && data_envelope
		|=> r.check == check_step(32'h0000_0000, $past(serial_bit)))
		else $error("New sector did not start a fresh check code.");

	a_new_ignored: assert property (
		r.state == burst_corrector_pkg::ST_CORRECT
		|=> r.state != burst_corrector_pkg::ST_CHECK)
		else $error("New sector accepted during correction.");

endmodule

//--- disk_controller_model.sv
`timescale 1ns/100ps
// Controller side of the link: counts every end-of-block pulse it receives.
module disk_controller_model (
	input  wire logic       clk,               // Clock.
	input  wire logic       rst_n,             // Reset, active low.
	input  wire logic       sector_end_signal, // End-of-block pulse.
	output logic      [7:0] end_count          // Pulses seen.
);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			end_count <= 8'h00;
		end else begin
			end_count <= end_count + {7'h00, sector_end_signal};
		end
	end
endmodule

//--- testbench.sv
`timescale 1ns/100ps
`include "burst_corrector_defs.svh"
module testbench;
	logic        clk, rst_n, cyc, stb, we, ra, de, ce, sb, ack, send;
	logic        attention, ready;
	logic [7:0]  adr, ends;
	logic [3:0]  sel, sel_req;
	logic [31:0] wdat, rdo, rdat, keep;
	int          err_total, comparisons, n, hn [2];

	burst_corrector #(.LEAD_ZEROS_16(16'h0008),
		.LEAD_ZEROS_18(16'h000C)) i_burst_corrector (
		.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdo), .wb_ack_o(ack), .read_active(ra),
		.data_envelope(de), .check_envelope(ce), .serial_bit(sb),
		.sector_end_signal(send), .attention(attention),
		.correction_ready(ready));
	disk_controller_model i_disk_controller_model (.clk(clk),
		.rst_n(rst_n), .sector_end_signal(send), .end_count(ends));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report;
		if (err_total == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One classic cycle; the request stands until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= sel_req;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rdat = rdo;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// Sixteen zero data bits, then the 32-bit check field, first bit first.
	task automatic feed(input logic [31:0] code);
		@(posedge clk);
		ra <= 1'b1;
		de <= 1'b1;
		sb <= 1'b0;
		repeat (16) @(posedge clk);
		de <= 1'b0;
		ce <= 1'b1;
		for (int i = 31; i >= 0; i--) begin
			sb <= code[i];
			@(posedge clk);
		end
		ce <= 1'b0;
		sb <= ~code[0];
	endtask

	task automatic wait_end(output int k);
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (send !== 1'b1 && k < 6000);
		if (k >= 6000) err_total++;
		ra <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_clean;
		wb(0, `OFS_CONTROL, 0);
		check("control", rdat, 0);
		wb(0, 8'h1C, 0);
		check("unmapped", rdat, 0);
		feed(32'h0000_0000);
		wait_end(n);
		check("clean end", 32'(n <= 3), 1);
		wb(0, `OFS_ERROR1, 0);
		check("clean error1", rdat, 0);
	endtask

	task automatic t_correct;
		keep = {24'h0, ends};
		feed(32'h0000_0001);
		wait_end(n);
		check("end delayed", 32'(n > 3), 1);
		@(posedge clk);
		check("ready", ready, 1);
		check("attention", attention, 1);
		wb(0, `OFS_ERROR1, 0);
		check("error1", rdat, 32'h0000_8000);
		wb(0, `OFS_CHECK, 0);
		check("trapped check", rdat, 32'h0020_0000);
		wb(0, `OFS_PATTERN, 0);
		check("pattern", rdat, 32'h0000_0001);
		wb(0, `OFS_STATUS, 0);
		check("corr en off", rdat[0], 0);
		wb(0, `OFS_SHIFTS, 0);
		keep[31:8] = rdat[23:0];
		repeat (10) @(posedge clk);
		wb(0, `OFS_SHIFTS, 0);
		check("shifts held", rdat[23:0], keep[31:8]);
		wb(0, `OFS_POSITION, 0);
		check("lead zeros", keep[31:8] - rdat[23:0], 8);
		check("one end", ends, keep[7:0] + 8'h01);
		wb(1, `OFS_ERROR1, 32'h0000_C000);
		wb(0, `OFS_ERROR1, 0);
		check("error1 clear", rdat, 0);
	endtask

	// A mid-run reset drops the trapped result and every control bit.
	task automatic t_reset;
		wb(1, `OFS_CONTROL, 32'h0000_0003);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check("reset ready", ready, 0);
		check("reset ends", ends, 0);
		wb(0, `OFS_CONTROL, 0);
		check("reset control", rdat, 0);
	endtask

	task automatic t_inhibit;
		sel_req = 4'hE;
		wb(1, `OFS_CONTROL, 32'h0000_0001);
		sel_req = 4'hF;
		wb(0, `OFS_CONTROL, 0);
		check("masked write", rdat, 0);
		wb(1, `OFS_CONTROL, 32'h0000_0001);
		feed(32'h0000_0001);
		wait_end(n);
		check("inhibit end", 32'(n <= 3), 1);
		wb(0, `OFS_STATUS, 0);
		check("inhibit corr en", rdat[0], 0);
		check("inhibit ready", ready, 0);
		wb(0, `OFS_ERROR1, 0);
		check("inhibit error1", rdat, 32'h0000_8000);
		wb(1, `OFS_ERROR1, 32'h0000_C000);
		wb(1, `OFS_CONTROL, 0);
	endtask

	// Two error bits twenty apart never fit the pattern field together.
	task automatic t_hard;
		for (int f = 0; f < 2; f++) begin
			wb(1, `OFS_CONTROL, 32'(f << 1));
			feed(32'h0010_0001);
			wait_end(hn[f]);
			wb(0, `OFS_ERROR1, 0);
			check("hard error1", rdat, 32'h0000_C000);
			check("hard ready", ready, 0);
			wb(1, `OFS_ERROR1, 32'h0000_C000);
		end
		// End detect, correction start and the end pulse add 3 cycles.
		check("hard 16", hn[0], 4128 + 8 + 3);
		check("format span", 32'(hn[1] - hn[0]), 4640 - 4128 + 4);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		#80000;
		err_total++;
		final_report();
	end

	initial begin
		{rst_n, cyc, stb, we, ra, de, ce, sb} = 8'h00;
		sel = 4'h0;
		sel_req = 4'hF;
		adr = 8'h00;
		wdat = 32'h0000_0000;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_clean();
		t_correct();
		t_reset();
		t_inhibit();
		t_hard();
		final_report();
	end
endmodule
